// *** src/dlm_top.sv ***
// Dual channel limit monitor: sticky limit flags, limit registers, indicator pin.
// Assumes conversion results arrive with a one-cycle valid strobe on the system clock.
`timescale 1ns/1ps
`default_nettype none
module dlm_top
	import dlm_pkg::*;
#(
	parameter int RES_W = 16
) (
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_N_I,
	input  wire logic [3:0]  ADDR_I,
	input  wire logic [15:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [15:0] RDATA_O,
	input  wire logic        RES_VALID_I,
	input  wire logic [15:0] RES_A_I,
	input  wire logic [15:0] RES_B_I,
	input  wire logic        LANE_B_DATA_I,
	output logic             LANE_B_OR_IND_O,
	output logic             IRQ_O
);
	// Comparison values are built from 12-bit fields over a 16-bit result; other widths refused.
	if (RES_W != 16) begin : g_bad_res_w
		$error("dlm_top supports a 16-bit result only");
	end

	// Reset release through two flip-flops; assertion stays asynchronous.
	logic rst_s1_ff;
	logic rst_n;
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_s1_ff <= 1'b0;
			rst_n     <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n     <= rst_s1_ff;
		end
	end

	logic [11:0] lower_ff;
	logic [11:0] upper_ff;
	logic [5:0]  status_ff;
	logic [5:0]  mask_ff;
	logic        output_lane_select_ff;
	logic        ind_en_ff;
	logic [15:0] rdata_ff;
	logic [5:0]  nxt_status;
	logic [15:0] nxt_rdata;

	// Register decode. The address field in the write data must match the port address.
	wire addr_ok  = (WDATA_I[ADDR_MSB:ADDR_LSB] == ADDR_I);
	wire wr_lower = WR_I && addr_ok && (ADDR_I == ADDR_LOWER);
	wire wr_upper = WR_I && addr_ok && (ADDR_I == ADDR_UPPER);
	wire wr_ctrl  = WR_I && addr_ok && (ADDR_I == ADDR_CTRL);
	wire wr_mask  = WR_I && addr_ok && (ADDR_I == ADDR_MASK);
	wire wr_stat  = WR_I && addr_ok && (ADDR_I == ADDR_STATUS);
	wire rd_stat  = RD_I && (ADDR_I == ADDR_STATUS);
	// Unmapped addresses read as all zeros, address field included.
	wire addr_mapped = (ADDR_I == ADDR_STATUS) || (ADDR_I == ADDR_LOWER) || (ADDR_I == ADDR_UPPER)
		|| (ADDR_I == ADDR_CTRL) || (ADDR_I == ADDR_MASK);

	// Internal comparison values with fixed low bits.
	wire [15:0] lower_val = {lower_ff, LOWER_FILL};
	wire [15:0] upper_val = {upper_ff, UPPER_FILL};

	// One comparator per channel; both channels share the same limits.
	logic [RES_W-1:0] res_ch [2];
	logic [1:0]       ch_under;
	logic [1:0]       ch_over;
	assign res_ch[0] = RES_A_I;
	assign res_ch[1] = RES_B_I;
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		dlm_cmp #(
			.W(RES_W)
		) i_dlm_cmp (
			.result_i(res_ch[ch]),
			.lower_i (lower_val),
			.upper_i (upper_val),
			.under_o (ch_under[ch]),
			.over_o  (ch_over[ch])
		);
	end

	// Channel A owns the low status pair, channel B the high pair.
	wire a_under = ch_under[0];
	wire a_over  = ch_over[0];
	wire b_under = ch_under[1];
	wire b_over  = ch_over[1];

	// Events of this result; only taken on a valid strobe.
	wire [5:0] hits   = {b_over, b_under, 2'b00, a_over, a_under};
	wire [5:0] events = {6{RES_VALID_I}} & hits;

	// Read clears all flags, writing ones clears chosen flags, a new event wins over either.
	wire [5:0] clr_bits = rd_stat ? FLAG_BITS : (wr_stat ? WDATA_I[5:0] : 6'h00);
	assign nxt_status = ((status_ff & ~clr_bits) | events) & FLAG_BITS;

	// Read data: address in the top nibble, reserved bits zero.
	always_comb begin
		nxt_rdata = 16'h0000;
		nxt_rdata[ADDR_MSB:ADDR_LSB] = ADDR_I;
		case (ADDR_I)
			ADDR_STATUS: nxt_rdata[5:0] = status_ff & FLAG_BITS;
			ADDR_LOWER:  nxt_rdata[11:0] = lower_ff;
			ADDR_UPPER:  nxt_rdata[11:0] = upper_ff;
			ADDR_CTRL:   nxt_rdata[1:0] = {ind_en_ff, output_lane_select_ff};
			ADDR_MASK:   nxt_rdata[5:0] = mask_ff;
			default:     nxt_rdata = 16'h0000;
		endcase
	end

	// Register storage.
	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			lower_ff              <= RST_LOWER;
			upper_ff              <= RST_UPPER;
			status_ff             <= RST_STATUS;
			mask_ff               <= RST_MASK;
			output_lane_select_ff <= 1'b0;
			ind_en_ff             <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			if (wr_lower) lower_ff <= WDATA_I[11:0];
			if (wr_upper) upper_ff <= WDATA_I[11:0];
			if (wr_mask) mask_ff <= WDATA_I[5:0] & FLAG_BITS;
			if (wr_ctrl) begin
				output_lane_select_ff <= WDATA_I[BIT_LANE_SEL];
				ind_en_ff             <= WDATA_I[BIT_IND_EN];
			end
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= RD_I ? nxt_rdata : 16'h0000;
		end
	end
	assign RDATA_O = rdata_ff;

	// Shared pin: indicator only in single-wire mode with the enable set, else lane B data.
	wire ind_mode = output_lane_select_ff && ind_en_ff;
	wire any_flag = |status_ff;
	assign LANE_B_OR_IND_O = ind_mode ? any_flag : LANE_B_DATA_I;
	assign IRQ_O = |(status_ff & mask_ff);

	// Checks.
	property p_a_over;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		(RES_VALID_I && RES_A_I > {upper_ff, UPPER_FILL}) |=> status_ff[BIT_A_OVER];
	endproperty
	a_a_over: assert property (p_a_over) else $error("A over flag not set");
	property p_a_under;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		(RES_VALID_I && RES_A_I < {lower_ff, LOWER_FILL}) |=> status_ff[BIT_A_UNDER];
	endproperty
	a_a_under: assert property (p_a_under) else $error("A under flag not set");
	property p_b_over;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		(RES_VALID_I && RES_B_I > {upper_ff, UPPER_FILL}) |=> status_ff[BIT_B_OVER];
	endproperty
	a_b_over: assert property (p_b_over) else $error("B over flag not set");
	property p_b_under;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		(RES_VALID_I && RES_B_I < {lower_ff, LOWER_FILL}) |=> status_ff[BIT_B_UNDER];
	endproperty
	a_b_under: assert property (p_b_under) else $error("B under flag not set");
	property p_sticky;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		(!rd_stat && !wr_stat) |=> ((status_ff & $past(status_ff)) == $past(status_ff));
	endproperty
	a_sticky: assert property (p_sticky) else $error("Flag dropped without clear");
	property p_rsvd;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		RD_I && ADDR_I == ADDR_STATUS |=> RDATA_O[11:6] == 6'h00 && RDATA_O[3:2] == 2'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("Reserved status bits not zero");
	property p_rd_clear;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		(rd_stat && !RES_VALID_I) |=> status_ff == 6'h00;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("Status read did not clear");
	property p_addr_echo;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		RD_I && addr_mapped |=> RDATA_O[15:12] == $past(ADDR_I);
	endproperty
	a_addr_echo: assert property (p_addr_echo) else $error("Address not in read word");
	property p_pin;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		!output_lane_select_ff |-> LANE_B_OR_IND_O == LANE_B_DATA_I;
	endproperty
	a_pin: assert property (p_pin) else $error("Pin not carrying lane B data");
	property p_ind;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		ind_mode |-> LANE_B_OR_IND_O == (status_ff != 6'h00);
	endproperty
	a_ind: assert property (p_ind) else $error("Indicator wrong");

	// Limit fields checked on the result's top twelve bits, so the fill nibble cannot hide a slip.
	property p_low_field;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		(RES_VALID_I && RES_A_I[15:4] < lower_ff) |=> status_ff[BIT_A_UNDER];
	endproperty
	a_low_field: assert property (p_low_field) else $error("Lower field not honoured");
	property p_high_field;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		(RES_VALID_I && RES_B_I[15:4] > upper_ff) |=> status_ff[BIT_B_OVER];
	endproperty
	a_high_field: assert property (p_high_field) else $error("Upper field not honoured");
	// A write lands only when the address field matches the port address.
	property p_wr_lower;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		wr_lower |=> lower_ff == $past(WDATA_I[11:0]);
	endproperty
	a_wr_lower: assert property (p_wr_lower) else $error("Lower limit write lost");
	property p_wr_upper;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		wr_upper |=> upper_ff == $past(WDATA_I[11:0]);
	endproperty
	a_wr_upper: assert property (p_wr_upper) else $error("Upper limit write lost");
	property p_wr_refused;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		(WR_I && WDATA_I[ADDR_MSB:ADDR_LSB] != ADDR_I)
			|=> $stable(lower_ff) && $stable(upper_ff) && $stable(mask_ff);
	endproperty
	a_wr_refused: assert property (p_wr_refused) else $error("Mismatched write landed");
	// Reserved status bits never hold state.
	property p_rsvd_state;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		status_ff[3:2] == 2'b00;
	endproperty
	a_rsvd_state: assert property (p_rsvd_state) else $error("Reserved flag set");
	// Writing ones at the status address clears those flags when no new event arrives.
	property p_wr_clear;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		(wr_stat && !RES_VALID_I) |=> (status_ff & $past(WDATA_I[5:0])) == 6'h00;
	endproperty
	a_wr_clear: assert property (p_wr_clear) else $error("Write of ones did not clear");
	// Read data stand only in the cycle after a read; unmapped reads give all zeros.
	property p_rd_idle;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		!RD_I |=> RDATA_O == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("Read data without a read");
	property p_unmapped;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		(RD_I && !addr_mapped) |=> RDATA_O == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero");
	// The pin carries lane B data unless both select and enable are set.
	property p_ind_off;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		!ind_mode |-> LANE_B_OR_IND_O == LANE_B_DATA_I;
	endproperty
	a_ind_off: assert property (p_ind_off) else $error("Indicator shown while disabled");
	// Interrupt level follows the unmasked flags.
	property p_irq;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		IRQ_O == ((status_ff & mask_ff) != 6'h00);
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt level wrong");
	property p_cov_rd;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		(status_ff != 6'h00) ##1 rd_stat;
	endproperty
	c_cov_rd: cover property (p_cov_rd);
	property p_cov_both;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		RES_VALID_I && a_over && b_under;
	endproperty
	c_cov_both: cover property (p_cov_both);
	property p_cov_ind;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		ind_mode && any_flag;
	endproperty
	c_cov_ind: cover property (p_cov_ind);
	property p_cov_refused;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		WR_I && !addr_ok;
	endproperty
	c_cov_refused: cover property (p_cov_refused);
	property p_cov_wr_clear;
		@(posedge CLK_SYS_I) disable iff (!rst_n)
		wr_stat && ((status_ff & WDATA_I[5:0]) != 6'h00);
	endproperty
	c_cov_wr_clear: cover property (p_cov_wr_clear);
endmodule
`default_nettype wire

// *** src/dlm_pkg.sv ***
// Package for the dual channel limit monitor: register map, field layout, reset values.
// Assumes a 4-bit register address and 16-bit register words.
package dlm_pkg;
	localparam logic [3:0]  ADDR_STATUS   = 4'h3;
	localparam logic [3:0]  ADDR_LOWER    = 4'h4;
	localparam logic [3:0]  ADDR_UPPER    = 4'h5;
	localparam logic [3:0]  ADDR_CTRL     = 4'h6;
	localparam logic [3:0]  ADDR_MASK     = 4'h7;
	localparam int          ADDR_MSB      = 15;
	localparam int          ADDR_LSB      = 12;
	localparam int          BIT_A_UNDER   = 0;
	localparam int          BIT_A_OVER    = 1;
	localparam int          BIT_B_UNDER   = 4;
	localparam int          BIT_B_OVER    = 5;
	localparam int          BIT_LANE_SEL  = 0;
	localparam int          BIT_IND_EN    = 1;
	localparam logic [11:0] RST_LOWER     = 12'h800;
	localparam logic [11:0] RST_UPPER     = 12'h7ff;
	localparam logic [5:0]  RST_STATUS    = 6'h00;
	localparam logic [5:0]  RST_MASK      = 6'h00;
	localparam logic [3:0]  LOWER_FILL    = 4'h0;
	localparam logic [3:0]  UPPER_FILL    = 4'hf;
	localparam logic [5:0]  FLAG_BITS     = 6'h33;
endpackage

// *** src/dlm_cmp.sv ***
// Limit comparator for one channel.
// Assumes the result and the two comparison values share one clock-free path.
`timescale 1ns/1ps
`default_nettype none
module dlm_cmp #(
	parameter int W = 16
) (
	input  wire logic [W-1:0] result_i,
	input  wire logic [W-1:0] lower_i,
	input  wire logic [W-1:0] upper_i,
	output logic              under_o,
	output logic              over_o
);
	// Equal to a limit is treated as in range.
	assign under_o = (result_i < lower_i);
	assign over_o  = (result_i > upper_i);
endmodule
`default_nettype wire

// *** test/dlm_host.sv ***
// Host model that reaches the limit monitor registers over the plain port.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module dlm_host (
	input  wire logic        clk_i,
	input  wire logic [15:0] rdata_i,
	output logic      [3:0]  addr_o,
	output logic      [15:0] wdata_o,
	output logic             wr_o,
	output logic             rd_o
);
	// Idle cycles before each request, so a slow host can be shown too.
	int gap = 0;

	// The bus is quiet at time zero.
	initial begin
		addr_o = 4'h0;
		wdata_o = 16'h0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// One-cycle write; afterwards the lines show the inverse, so no stale value looks valid.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		repeat (gap) @(posedge clk_i);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask

	// One-cycle read; the data are taken mid-cycle, where they have settled.
	task automatic rd(input logic [3:0] a, output logic [15:0] q);
		repeat (gap) @(posedge clk_i);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(negedge clk_i);
		q = rdata_i;
	endtask
endmodule
`default_nettype wire

// *** test/test_dlm_top.sv ***
// Self-checking bench for the limit monitor: registers, sticky flags, interrupt, shared pin.
// Assumes the host model in dlm_host drives the register port.
`timescale 1ns/1ps
`default_nettype none
module test_dlm_top;
	logic        clk_sys, rst_n, res_valid, lane_b, wr, rd, pin, irq;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, res_a, res_b, q;
	int          err_count = 0;
	int          tests_run = 0;
	logic [15:0] ta [6] = '{16'h1000, 16'h0fff, 16'h2010, 16'h1000, 16'h1000, 16'h2010};
	logic [15:0] tb [6] = '{16'h200f, 16'h1000, 16'h1000, 16'h0fff, 16'h2010, 16'h0fff};
	logic [15:0] te [6] = '{16'h3000, 16'h3001, 16'h3002, 16'h3010, 16'h3020, 16'h3012};

	dlm_top i_dlm_top (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RES_VALID_I(res_valid), .RES_A_I(res_a),
		.RES_B_I(res_b), .LANE_B_DATA_I(lane_b), .LANE_B_OR_IND_O(pin), .IRQ_O(irq));
	dlm_host i_dlm_host (.clk_i(clk_sys), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd));

	// Clock at 50 MHz.
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
		i_dlm_host.rd(a, q);
		chk(q, exp);
	endtask

	// Pin and interrupt are levels, so two settled samples later is safe.
	task automatic sig(input logic [1:0] exp);
		repeat (2) @(negedge clk_sys);
		chk({14'h0, pin, irq}, {14'h0, exp});
	endtask

	// One result strobe; the inputs are scrambled afterwards so only the strobed pair counts.
	task automatic res(input logic [15:0] a, input logic [15:0] b);
		@(posedge clk_sys);
		res_a <= a;
		res_b <= b;
		res_valid <= 1'b1;
		@(posedge clk_sys);
		res_valid <= 1'b0;
		res_a <= ~a;
		res_b <= ~b;
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// A hang is cut short here and counted as a mismatch.
	initial begin
		#2000000;
		err_count++;
		results();
	end

	initial begin
		rst_n = 1'b0;
		res_valid = 1'b0;
		res_a = 16'h0;
		res_b = 16'h0;
		lane_b = 1'b0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		sig(2'b00);
		rchk(4'h3, 16'h3000);
		rchk(4'h4, 16'h4800);
		rchk(4'h5, 16'h57ff);
		rchk(4'hf, 16'h0000);
		res(16'h8000, 16'h7fff);
		rchk(4'h3, 16'h3012);
		$display("test reset done");
		i_dlm_host.gap = 2;
		i_dlm_host.wr(4'h4, 16'h4100);
		i_dlm_host.wr(4'h4, 16'h5123);
		i_dlm_host.wr(4'h5, 16'h5200);
		rchk(4'h4, 16'h4100);
		rchk(4'h5, 16'h5200);
		i_dlm_host.gap = 0;
		$display("test limits done");
		for (int i = 0; i < 6; i++) begin
			res(ta[i], tb[i]);
			rchk(4'h3, te[i]);
			rchk(4'h3, 16'h3000);
		end
		res(16'h0fff, 16'h1000);
		res(16'h1000, 16'h1000);
		rchk(4'h3, 16'h3001);
		$display("test flags done");
		i_dlm_host.wr(4'h7, 16'h7033);
		res(16'h0fff, 16'h1000);
		sig(2'b01);
		i_dlm_host.wr(4'h7, 16'h7000);
		sig(2'b00);
		i_dlm_host.wr(4'h7, 16'h7001);
		sig(2'b01);
		i_dlm_host.wr(4'h3, 16'h3001);
		sig(2'b00);
		$display("test interrupt done");
		@(posedge clk_sys);
		lane_b <= 1'b1;
		res(16'h0fff, 16'h1000);
		i_dlm_host.wr(4'h6, 16'h6002);
		sig(2'b11);
		i_dlm_host.wr(4'h6, 16'h6001);
		@(posedge clk_sys);
		lane_b <= 1'b0;
		sig(2'b01);
		i_dlm_host.wr(4'h6, 16'h6003);
		sig(2'b11);
		@(posedge clk_sys);
		lane_b <= 1'b1;
		rchk(4'h3, 16'h3001);
		sig(2'b00);
		$display("test pin done");
		res(16'h0fff, 16'h1000);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rchk(4'h3, 16'h3000);
		rchk(4'h4, 16'h4800);
		rchk(4'h5, 16'h57ff);
		sig(2'b10);
		$display("test second reset done");
		results();
	end
endmodule
`default_nettype wire
